// [core/triple_nibble_io_ports.sv]
// Three 4-bit general-purpose ports driven by core port commands
`timescale 1ns/1ps
module triple_nibble_io_ports #(
  parameter logic [11:0] IO_MASK = 12'hfff,
  parameter logic [2:0] PULL_OPT = 3'h7,
  parameter logic HOLD_OPT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core command port
  input wire logic cmd_valid,
  input wire nibble_io_pkg::cmd_e cmd_op,
  input wire logic [1:0] cmd_port,
  input wire logic [4:0] cmd_data,
  // Read answer
  output logic rd_valid,
  output logic [3:0] rd_data,
  // Pins, port A in bits 3:0, B in 7:4, C in 11:8
  input wire logic [11:0] pin_in,
  output logic [11:0] pin_out,
  output logic [11:0] pin_oe,
  output logic [11:0] pull_dn_en,
  output logic [3:0] hold_en_c,
  // Resistance-frequency counter oscillator pin
  input wire logic rfc_enable,
  output logic osc_sense
);
  import nibble_io_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] dir;
    logic [11:0] latch;
    logic [2:0] pull;
    logic gate;
    logic [11:0] pout;
    logic [11:0] poe;
    logic [11:0] pd;
    logic [3:0] hold;
    logic [3:0] rdat;
    logic rval;
    logic osc;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [11:0] v_out;
  logic [11:0] v_oe;
  logic [11:0] v_pd;
  logic [11:0] v_rd;
  logic strobe;
  logic ser_fire;

  // Port index to nibble offset, used by the direction, write and read paths
  function automatic int unsigned nib(input logic [1:0] p);
    nib = 4 * int'(p);
  endfunction : nib

  assign ser_fire = cmd_valid && (cmd_op == CMD_SERIAL) && cmd_data[4];

  // ----------------------------------------------------------------
  // Per-port views
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_port
      port_view u_view (
        .dir(st_nxt.dir[4*g +: 4]),
        .latch(st_nxt.latch[4*g +: 4]),
        .io_mask(IO_MASK[4*g +: 4]),
        .pull_on(st_nxt.pull[g] & PULL_OPT[g]),
        .pin_in(pin_in[4*g +: 4]),
        .drv_out(v_out[4*g +: 4]),
        .drv_oe(v_oe[4*g +: 4]),
        .pd_on(v_pd[4*g +: 4]),
        .rd_val(v_rd[4*g +: 4])
      );
    end
  endgenerate

  strobe_timer u_strobe (
    .clk(clk),
    .rst(rst),
    .fire(ser_fire),
    .pulse(strobe)
  );

  // ----------------------------------------------------------------
  // Command handling
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rval = 1'b0;
    if (cmd_valid && cmd_port != 2'h3)
    begin
      if (cmd_op == CMD_SET_DIR)
      begin
        st_nxt.dir[nib(cmd_port) +: 4] = cmd_data[3:0];
        st_nxt.pull[cmd_port] = cmd_data[OPND_PULL_BIT];
      end
      else if (cmd_op == CMD_WRITE)
      begin
        st_nxt.latch[nib(cmd_port) +: 4] = cmd_data[3:0];
      end
      else if (cmd_op == CMD_READ)
      begin
        st_nxt.rval = 1'b1;
        st_nxt.rdat = v_rd[nib(cmd_port) +: 4];
      end
    end
    if (cmd_valid && cmd_op == CMD_SERIAL)
    begin
      // Data bits and constant land in the latch; bit 3 follows strobe
      st_nxt.latch[1:0] = cmd_data[1:0];
      st_nxt.latch[SER_CONST_BIT] = cmd_data[4];
      st_nxt.gate = cmd_data[4];
    end
    st_nxt.pout = v_out;
    st_nxt.poe = v_oe;
    if (st_nxt.gate)
    begin
      // Strobe lags the data bits by one cycle through its own register
      st_nxt.pout[SER_STROBE_BIT] = strobe & v_oe[SER_STROBE_BIT];
    end
    st_nxt.pd = v_pd;
    st_nxt.hold = {4{HOLD_OPT & ~st_nxt.pull[2]}} & ~st_nxt.dir[11:8]
                  & IO_MASK[11:8];
    // Counter taps the pin itself, so it sees the output it drives too
    st_nxt.osc = rfc_enable & pin_in[OSC_PIN_BIT];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r.dir <= RST_DIR;
      st_r.latch <= RST_LATCH;
      st_r.pull <= RST_PULL;
      st_r.gate <= RST_GATE;
      st_r.pout <= 12'h000;
      st_r.poe <= 12'h000;
      st_r.pd <= 12'h000;
      st_r.hold <= 4'h0;
      st_r.rdat <= 4'h0;
      st_r.rval <= 1'b0;
      st_r.osc <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_valid = st_r.rval;
  assign rd_data = st_r.rdat;
  assign pin_out = st_r.pout;
  assign pin_oe = st_r.poe;
  assign pull_dn_en = st_r.pd;
  assign hold_en_c = st_r.hold;
  assign osc_sense = st_r.osc;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_dir_cmd;
    @(posedge clk) disable iff (rst)
    (cmd_valid && cmd_op == CMD_SET_DIR && cmd_port == PORT_B)
    |=> pin_oe[7:4] == ($past(cmd_data[3:0]) & IO_MASK[7:4]);
  endproperty
  a_dir_cmd: assert property (p_dir_cmd)
    else $error("direction command not applied to port B");

  property p_write_cmd;
    @(posedge clk) disable iff (rst)
    (cmd_valid && cmd_op == CMD_WRITE && cmd_port == PORT_C)
    |=> (pin_out[11:8] == ($past(cmd_data[3:0]) & pin_oe[11:8]));
  endproperty
  a_write_cmd: assert property (p_write_cmd)
    else $error("port C write data not on output pins");

  property p_read_cmd;
    @(posedge clk) disable iff (rst)
    (cmd_valid && cmd_op == CMD_READ && cmd_port == PORT_A)
    |=> rd_valid && rd_data == ((($past(st_r.dir[3:0]) & $past(st_r.latch[3:0]))
        | (~$past(st_r.dir[3:0]) & $past(pin_in[3:0]))) & IO_MASK[3:0]);
  endproperty
  a_read_cmd: assert property (p_read_cmd)
    else $error("port A read value wrong");

  property p_nonio;
    @(posedge clk) disable iff (rst)
    ((pin_oe | pull_dn_en) & ~IO_MASK) == 12'h000;
  endproperty
  a_nonio: assert property (p_nonio)
    else $error("non-I/O pin driven or pulled");

  property p_excl;
    @(posedge clk) disable iff (rst)
    (pull_dn_en[11:8] & hold_en_c) == 4'h0;
  endproperty
  a_excl: assert property (p_excl)
    else $error("port C pull-down and hold both on");

  property p_hold_cmd;
    @(posedge clk) disable iff (rst)
    (cmd_valid && cmd_op == CMD_SET_DIR && cmd_port == PORT_C
     && cmd_data == 5'h00)
    |=> hold_en_c == ({4{HOLD_OPT}} & IO_MASK[11:8]) && pull_dn_en[11:8] == 4'h0;
  endproperty
  a_hold_cmd: assert property (p_hold_cmd)
    else $error("operand 0h did not select low-level hold");

  property p_out_c;
    @(posedge clk) disable iff (rst)
    ((hold_en_c | pull_dn_en[11:8]) & pin_oe[11:8]) == 4'h0;
  endproperty
  a_out_c: assert property (p_out_c)
    else $error("port C output bit still pulled or held");

  property p_gate_open;
    @(posedge clk) disable iff (rst)
    (ser_fire && st_r.dir[SER_STROBE_BIT] && IO_MASK[SER_STROBE_BIT])
    |=> ##1 pin_out[SER_STROBE_BIT] [*8];
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("no strobe after pseudo-serial command");

  property p_gate_close;
    @(posedge clk) disable iff (rst)
    (cmd_valid && cmd_op == CMD_SERIAL && !cmd_data[4]) |=> !st_r.gate;
  endproperty
  a_gate_close: assert property (p_gate_close)
    else $error("shift gate did not close");

  property p_osc;
    @(posedge clk) disable iff (rst)
    (rfc_enable && $changed(pin_in[OSC_PIN_BIT])) |=> osc_sense == $past(pin_in[1]);
  endproperty
  a_osc: assert property (p_osc)
    else $error("counter missed oscillator pin change");

  c_read: cover property (@(posedge clk) disable iff (rst) rd_valid);
  c_serial: cover property (@(posedge clk) disable iff (rst)
    ser_fire ##[1:40] (cmd_valid && cmd_op == CMD_SERIAL && !cmd_data[4]));
  c_hold: cover property (@(posedge clk) disable iff (rst) hold_en_c != 4'h0);
endmodule : triple_nibble_io_ports

// [shared/nibble_io_pkg.sv]
// Constants and types shared by the triple nibble I/O ports
package nibble_io_pkg;
  // ----------------------------------------------------------------
  // Commands from the core and port select
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_IDLE = 3'b000,
    CMD_SET_DIR = 3'b001,
    CMD_WRITE = 3'b010,
    CMD_READ = 3'b011,
    CMD_SERIAL = 3'b100
  } cmd_e;
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int OPND_PULL_BIT = 4;
  localparam int SER_CONST_BIT = 2;
  localparam int SER_STROBE_BIT = 3;
  localparam int OSC_PIN_BIT = 1;
  localparam logic [11:0] RST_DIR = 12'h000;
  localparam logic [11:0] RST_LATCH = 12'h000;
  localparam logic [2:0] RST_PULL = 3'h7;
  localparam logic RST_GATE = 1'b0;
  // ----------------------------------------------------------------
  // Strobe timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int STROBE_NS = 1000;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
endpackage : nibble_io_pkg

// [core/port_view.sv]
// Combinational view of one nibble port: drive, pull-down and read-back
`timescale 1ns/1ps
module port_view (
  // Port state
  input wire logic [3:0] dir,
  input wire logic [3:0] latch,
  input wire logic [3:0] io_mask,
  input wire logic pull_on,
  // Pins
  input wire logic [3:0] pin_in,
  // Results
  output logic [3:0] drv_out,
  output logic [3:0] drv_oe,
  output logic [3:0] pd_on,
  output logic [3:0] rd_val
);
  import nibble_io_pkg::*;
  // Non-I/O pins see neither input nor output behaviour
  assign drv_oe = dir & io_mask;
  assign drv_out = latch & drv_oe;
  assign pd_on = {4{pull_on}} & ~dir & io_mask;
  assign rd_val = ((dir & latch) | (~dir & pin_in)) & io_mask;
endmodule : port_view

// [core/strobe_timer.sv]
// Fixed-width strobe pulse generator for the pseudo-serial clock bit
`timescale 1ns/1ps
module strobe_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic fire,
  // Pulse
  output logic pulse
);
  import nibble_io_pkg::*;
  logic [7:0] cnt_r;
  // A new fire restarts the pulse; back to back shifts merge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 8'h00;
    end
    else if (fire)
    begin
      cnt_r <= STROBE_CNT;
    end
    else if (cnt_r != 8'h00)
    begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign pulse = (cnt_r != 8'h00);
endmodule : strobe_timer

// [bench/ext_pins.sv]
// Board model: switches, loads and pull devices on the port pins
`timescale 1ns/1ps
module ext_pins (
  // Clock
  input wire logic clk,
  // Device side
  input wire logic [11:0] pin_out,
  input wire logic [11:0] pin_oe,
  input wire logic [11:0] pull_dn_en,
  input wire logic [3:0] hold_en_c,
  // Board switches
  input wire logic [11:0] ext_drive,
  input wire logic [11:0] ext_val,
  // Resolved levels
  output logic [11:0] pin_in
);
  logic [11:0] float_r = 12'h5a5;
  logic [11:0] low_keep;
  // --
  // Resolution
  // --
  // An unheld pin wanders, so a stale level never passes as a clean 0
  always @(posedge clk)
    float_r <= ~float_r;
  assign low_keep = pull_dn_en | {hold_en_c, 8'h00};
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_val)
    | (~pin_oe & ~ext_drive & ~low_keep & float_r);
endmodule : ext_pins

// [bench/testbench.sv]
// Self-checking bench for the triple nibble I/O ports
`timescale 1ns/1ps
module testbench;
  import nibble_io_pkg::*;
  localparam logic [11:0] MASK = 12'h7ff;
  logic clk, rst, cmd_valid, rd_valid, rfc_enable, osc_sense;
  cmd_e cmd_op;
  logic [1:0] cmd_port;
  logic [4:0] cmd_data;
  logic [3:0] rd_data, hold_en_c;
  logic [11:0] pin_in, pin_out, pin_oe, pull_dn_en, ext_drive, ext_val;
  int fail_count, checks, cyc;
  // --
  // Design and board
  // --
  // Top pin of port C is left non-I/O to exercise the option mask
  triple_nibble_io_ports #(.IO_MASK(MASK), .PULL_OPT(3'h7), .HOLD_OPT(1'b1))
    u_triple_nibble_io_ports (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_port(cmd_port), .cmd_data(cmd_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_dn_en(pull_dn_en), .hold_en_c(hold_en_c), .rfc_enable(rfc_enable),
    .osc_sense(osc_sense));
  ext_pins u_ext_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_dn_en(pull_dn_en), .hold_en_c(hold_en_c), .ext_drive(ext_drive),
    .ext_val(ext_val), .pin_in(pin_in));
  // --
  // Helpers
  // --
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Command stays up; repeats are harmless until quiet drops it
  task automatic send(input cmd_e op, input logic [1:0] port, input logic [4:0] data);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_port = port;
    cmd_data = data;
    @(posedge clk);
    #1;
  endtask : send
  task automatic quiet;
    cmd_valid = 1'b0;
    cmd_op = CMD_IDLE;
    @(posedge clk);
    #1;
  endtask : quiet
  task automatic test_done;
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // --
  // Scenarios
  // --
  task automatic t_reset;
    check(pin_oe, 12'h000);
    check(pull_dn_en, MASK);
    check(hold_en_c, 12'h000);
  endtask : t_reset
  // Latch bit 3 set so a gate left open shows up after the close
  task automatic t_serial;
    send(CMD_WRITE, PORT_A, 5'h08);
    send(CMD_SET_DIR, PORT_A, 5'h1f);
    send(CMD_SERIAL, PORT_A, 5'h12);
    check(pin_out, 12'h006);
    quiet();
    check(pin_out, 12'h00e);
    repeat (19) @(posedge clk);
    #1;
    check(pin_out[3], 1'b1);
    @(posedge clk);
    #1;
    check(pin_out[3], 1'b0);
    send(CMD_SERIAL, PORT_A, 5'h01);
    quiet();
    check(pin_out, 12'h009);
  endtask : t_serial
  task automatic t_osc;
    rfc_enable = 1'b1;
    send(CMD_WRITE, PORT_A, 5'h02);
    quiet();
    check(osc_sense, 1'b1);
    rfc_enable = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(osc_sense, 1'b0);
  endtask : t_osc
  task automatic t_port_ab;
    send(CMD_WRITE, PORT_A, 5'h05);
    send(CMD_SET_DIR, PORT_A, 5'h03);
    quiet();
    check(pin_oe, 12'h003);
    check(pin_out, 12'h001);
    check(pull_dn_en, 12'h7f0);
    send(CMD_READ, PORT_A, 5'h00);
    check(rd_valid, 1'b1);
    check(rd_data, 12'h009);
    quiet();
    check(rd_valid, 1'b0);
    send(CMD_WRITE, PORT_B, 5'h0a);
    send(CMD_SET_DIR, PORT_B, 5'h1f);
    quiet();
    check(pin_out, 12'h0a1);
    check(pin_oe, 12'h0f3);
  endtask : t_port_ab
  task automatic t_port_c;
    send(CMD_SET_DIR, PORT_C, 5'h00);
    quiet();
    check(hold_en_c, 12'h007);
    check(pull_dn_en[11:8], 12'h000);
    send(CMD_SET_DIR, PORT_C, 5'h10);
    quiet();
    check(hold_en_c, 12'h000);
    check(pull_dn_en[11:8], 12'h007);
    send(CMD_WRITE, PORT_C, 5'h0f);
    send(CMD_SET_DIR, PORT_C, 5'h0b);
    quiet();
    check(hold_en_c, 12'h004);
    check(pin_oe, 12'h3f3);
    send(CMD_SET_DIR, PORT_C, 5'h13);
    quiet();
    check(pull_dn_en[11:8], 12'h004);
    send(CMD_READ, PORT_C, 5'h00);
    check(rd_data, 12'h007);
    send(CMD_SET_DIR, 2'h3, 5'h1f);
    quiet();
    check(pin_oe, 12'h3f3);
  endtask : t_port_c
  // --
  // Sequence
  // --
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = CMD_IDLE;
    cmd_port = 2'h0;
    cmd_data = 5'h00;
    rfc_enable = 1'b0;
    ext_drive = 12'hfff;
    ext_val = 12'hf08;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_serial();
    t_osc();
    t_port_ab();
    t_port_c();
    test_done();
  end
endmodule : testbench
